// ### core/eli_cfg.svh
`ifndef ELI_CFG_SVH
`define ELI_CFG_SVH

// Blink timing in milliseconds and the derived cycle counts at 200 MHz.
`define ELI_CLK_HZ        200000000
`define ELI_FLASH_ON_MS   200
`define ELI_FLASH_OFF_MS  200
`define ELI_GAP_MS        1000
`define ELI_FLASH_ON_CYC  ((`ELI_CLK_HZ / 1000) * `ELI_FLASH_ON_MS)
`define ELI_FLASH_OFF_CYC ((`ELI_CLK_HZ / 1000) * `ELI_FLASH_OFF_MS)
`define ELI_GAP_CYC       ((`ELI_CLK_HZ / 1000) * `ELI_GAP_MS)
`define ELI_CNT_W         28
`define ELI_PH_W          3
`define ELI_FLASH_ONE     3'h1
`define ELI_FLASH_TWO     3'h2
`define ELI_FLASH_THREE   3'h3
`define ELI_PH_ZERO       3'h0

`endif

// ### core/eli_pkg.sv
package eli_pkg;

  typedef enum logic [2:0] {
    ELI_SHOW_NONE,
    ELI_SHOW_WARN,
    ELI_SHOW_GUARD,
    ELI_SHOW_SYNC,
    ELI_SHOW_BUSOFF
  } eli_show_type;

  typedef enum logic [1:0] {
    ELI_ST_ON,
    ELI_ST_OFF,
    ELI_ST_GAP
  } eli_state_type;

endpackage

// ### core/eli_error_led.sv
`include "eli_cfg.svh"

module eli_error_led
  import eli_pkg::*;
#(
  parameter logic [`ELI_CNT_W-1:0] FLASH_ON_CYC  =
    `ELI_CNT_W'(`ELI_FLASH_ON_CYC),
  parameter logic [`ELI_CNT_W-1:0] FLASH_OFF_CYC =
    `ELI_CNT_W'(`ELI_FLASH_OFF_CYC),
  parameter logic [`ELI_CNT_W-1:0] GAP_CYC       =
    `ELI_CNT_W'(`ELI_GAP_CYC)
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic warn_level,
  input  wire logic guard_event,
  input  wire logic sync_timeout,
  input  wire logic bus_off,
  output logic      err_lamp
);

  typedef struct packed {
    eli_state_type          st;
    eli_show_type           show;
    logic [`ELI_PH_W-1:0]   flashes;
    logic [`ELI_CNT_W-1:0]  cnt;
    logic                   lamp;
  } eli_reg_type;

  eli_reg_type r_q;
  eli_reg_type r_d;
  eli_show_type sel;
  logic [`ELI_PH_W-1:0] want;
  logic last;

  // The priority chain picks the most severe active source.
  always_comb begin
    if (bus_off) begin
      sel = ELI_SHOW_BUSOFF;
    end else if (sync_timeout) begin
      sel = ELI_SHOW_SYNC;
    end else if (guard_event) begin
      sel = ELI_SHOW_GUARD;
    end else if (warn_level) begin
      sel = ELI_SHOW_WARN;
    end else begin
      sel = ELI_SHOW_NONE;
    end
  end

  always_comb begin
    case (r_q.show)
      ELI_SHOW_WARN:  want = `ELI_FLASH_ONE;
      ELI_SHOW_GUARD: want = `ELI_FLASH_TWO;
      ELI_SHOW_SYNC:  want = `ELI_FLASH_THREE;
      default:        want = `ELI_PH_ZERO;
    endcase
  end

  assign last = (r_q.cnt <= {{(`ELI_CNT_W-1){1'b0}}, 1'b1});

  always_comb begin
    r_d = r_q;
    r_d.cnt = r_q.cnt - {{(`ELI_CNT_W-1){1'b0}}, 1'b1};
    if (sel != r_q.show) begin
      // A change of source restarts its pattern at once.
      r_d.show = sel;
      r_d.st = ELI_ST_ON;
      r_d.flashes = `ELI_PH_ZERO;
      r_d.cnt = FLASH_ON_CYC;
      r_d.lamp = (sel != ELI_SHOW_NONE);
    end else if (r_q.show == ELI_SHOW_NONE) begin
      r_d.lamp = 1'b0;
      r_d.cnt = r_q.cnt;
    end else if (r_q.show == ELI_SHOW_BUSOFF) begin
      r_d.lamp = 1'b1;
      r_d.cnt = r_q.cnt;
    end else if (last) begin
      case (r_q.st)
        ELI_ST_ON: begin
          r_d.flashes = r_q.flashes + `ELI_FLASH_ONE;
          r_d.lamp = 1'b0;
          if ((r_q.flashes + `ELI_FLASH_ONE) >= want) begin
            r_d.st = ELI_ST_GAP;
            r_d.cnt = GAP_CYC;
          end else begin
            r_d.st = ELI_ST_OFF;
            r_d.cnt = FLASH_OFF_CYC;
          end
        end
        ELI_ST_OFF: begin
          r_d.st = ELI_ST_ON;
          r_d.lamp = 1'b1;
          r_d.cnt = FLASH_ON_CYC;
        end
        ELI_ST_GAP: begin
          r_d.st = ELI_ST_ON;
          r_d.lamp = 1'b1;
          r_d.flashes = `ELI_PH_ZERO;
          r_d.cnt = FLASH_ON_CYC;
        end
        default: begin
          r_d.st = ELI_ST_GAP;
          r_d.lamp = 1'b0;
          r_d.cnt = GAP_CYC;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_q <= '{st: ELI_ST_GAP, show: ELI_SHOW_NONE, flashes: `ELI_PH_ZERO,
               cnt: '0, lamp: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  assign err_lamp = r_q.lamp;

  property p_dark;
    @(posedge ref_clk) disable iff (!resetn)
      (!bus_off && !sync_timeout && !guard_event && !warn_level)[*2]
      |-> !err_lamp;
  endproperty
  a_dark: assert property (p_dark)
    else $error("Lamp lit with no error.");

  property p_busoff;
    @(posedge ref_clk) disable iff (!resetn)
      bus_off ##1 bus_off |-> err_lamp;
  endproperty
  a_busoff: assert property (p_busoff)
    else $error("Lamp dark during bus-off.");

  property p_sync_wins;
    @(posedge ref_clk) disable iff (!resetn)
      sync_timeout && !bus_off |=> r_q.show == ELI_SHOW_SYNC;
  endproperty
  a_sync_wins: assert property (p_sync_wins)
    else $error("SYNC timeout not selected.");

  property p_rank;
    @(posedge ref_clk) disable iff (!resetn)
      guard_event && warn_level && !sync_timeout && !bus_off
      |=> r_q.show == ELI_SHOW_GUARD;
  endproperty
  a_rank: assert property (p_rank)
    else $error("Guarding event not ranked over warning.");

  property p_flash_count;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.st == ELI_ST_GAP && r_q.show != ELI_SHOW_NONE
      && r_q.show != ELI_SHOW_BUSOFF |-> r_q.flashes == want;
  endproperty
  a_flash_count: assert property (p_flash_count)
    else $error("Wrong flash count before gap.");

  property p_triple;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.show == ELI_SHOW_SYNC && r_q.st == ELI_ST_GAP
      |-> r_q.flashes == `ELI_FLASH_THREE;
  endproperty
  a_triple: assert property (p_triple)
    else $error("SYNC pattern is not three flashes.");

  property p_gap_dark;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.st == ELI_ST_GAP && r_q.show == $past(r_q.show) |-> !err_lamp;
  endproperty
  a_gap_dark: assert property (p_gap_dark)
    else $error("Lamp lit in pattern gap.");

  property p_start;
    @(posedge ref_clk) disable iff (!resetn)
      warn_level && !guard_event && !sync_timeout && !bus_off
      && r_q.show == ELI_SHOW_NONE |=> err_lamp;
  endproperty
  a_start: assert property (p_start)
    else $error("Warning pattern did not start.");

  property p_none_dark;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.show == ELI_SHOW_NONE |-> !err_lamp;
  endproperty
  a_none_dark: assert property (p_none_dark)
    else $error("Lamp lit with no source selected.");

  property p_on_lit;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.st == ELI_ST_ON && r_q.show != ELI_SHOW_NONE |-> err_lamp;
  endproperty
  a_on_lit: assert property (p_on_lit)
    else $error("Lamp dark during a flash.");

  property p_off_dark;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.st == ELI_ST_OFF |-> !err_lamp;
  endproperty
  a_off_dark: assert property (p_off_dark)
    else $error("Lamp lit between flashes.");

  property p_double;
    @(posedge ref_clk) disable iff (!resetn)
      r_q.show == ELI_SHOW_GUARD && r_q.st == ELI_ST_GAP
      |-> r_q.flashes == `ELI_FLASH_TWO;
  endproperty
  a_double: assert property (p_double)
    else $error("Guarding pattern is not two flashes.");

  c_busoff: cover property (@(posedge ref_clk) bus_off ##1 err_lamp);
  c_sync: cover property (@(posedge ref_clk)
    r_q.show == ELI_SHOW_SYNC && r_q.st == ELI_ST_GAP);
  c_guard: cover property (@(posedge ref_clk)
    r_q.show == ELI_SHOW_GUARD && r_q.st == ELI_ST_GAP);
  c_warn: cover property (@(posedge ref_clk)
    r_q.show == ELI_SHOW_WARN && r_q.st == ELI_ST_GAP);

endmodule

// ### verif/eli_lamp_model.sv
module eli_lamp_model (
  input wire logic ref_clk,
  input wire logic err_lamp,
  output logic     glow
);
  timeunit 1ns;
  timeprecision 1ps;
  // The eye looks at the lamp once a cycle, midway between edges.
  always @(negedge ref_clk) begin
    glow = err_lamp;
  end
endmodule

// ### verif/tb_eli_error_led.sv
module tb_eli_error_led;
  timeunit 1ns;
  timeprecision 1ps;
  import eli_pkg::*;
  localparam int ON  = 4;
  localparam int OFF = 4;
  localparam int GAP = 10;
  logic       ref_clk      = 1'b0;
  logic       resetn       = 1'b0;
  logic       warn_level   = 1'b0;
  logic       guard_event  = 1'b0;
  logic       sync_timeout = 1'b0;
  logic       bus_off      = 1'b0;
  logic       err_lamp;
  logic       glow;
  logic [7:0] rnd          = 8'h3A;
  logic       exp_q[$];
  int         mismatches   = 0;
  int         n_tests      = 0;
  int         seq[10]      = '{1, 2, 3, 4, 0, 3, 1, 4, 2, 0};

  eli_error_led #(
    .FLASH_ON_CYC (28'h4),
    .FLASH_OFF_CYC(28'h4),
    .GAP_CYC      (28'hA)
  ) u_eli_error_led (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .warn_level  (warn_level),
    .guard_event (guard_event),
    .sync_timeout(sync_timeout),
    .bus_off     (bus_off),
    .err_lamp    (err_lamp)
  );

  eli_lamp_model u_eli_lamp_model (
    .ref_clk (ref_clk),
    .err_lamp(err_lamp),
    .glow    (glow)
  );

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Expected lamp level k cycles into the pattern of winner w.
  function automatic logic lamp_at(input int w, input int k);
    int t;
    if (w == 0) return 1'b0;
    if (w == 4) return 1'b1;
    t = k % (w * ON + (w - 1) * OFF + GAP);
    for (int i = 0; i < w; i++) begin
      if (t >= i * (ON + OFF) && t < i * (ON + OFF) + ON) return 1'b1;
    end
    return 1'b0;
  endfunction

  task automatic check_lamp(input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH err_lamp expected %b seen %b", e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Winner w raised with random lower sources beneath it.
  task automatic run(input int w);
    logic [3:0] v;
    rnd = lfsr(rnd);
    v = (w == 0) ? 4'h0 : 4'((1 << (w - 1)) | (rnd & ((1 << (w - 1)) - 1)));
    @(posedge ref_clk);
    {bus_off, sync_timeout, guard_event, warn_level} <= v;
    for (int k = 0; k < 70; k++) begin
      @(posedge ref_clk);
      exp_q.push_back(lamp_at(w, k));
    end
    $display("Test with winner %0d done", w);
  endtask

  // A reset in mid-pattern darkens the lamp at once and restarts cleanly.
  task automatic reset_mid();
    @(posedge ref_clk);
    bus_off <= 1'b1;
    repeat (3) begin
      @(posedge ref_clk);
      exp_q.push_back(1'b1);
    end
    @(posedge ref_clk);
    {resetn, bus_off} <= 2'h0;
    exp_q.push_back(1'b0);
    repeat (3) begin
      @(posedge ref_clk);
      exp_q.push_back(1'b0);
    end
    resetn <= 1'b1;
    @(posedge ref_clk);
    bus_off <= 1'b1;
    exp_q.push_back(1'b0);
    @(posedge ref_clk);
    bus_off <= 1'b0;
    exp_q.push_back(1'b1);
    @(posedge ref_clk);
    exp_q.push_back(1'b0);
    $display("Test with reset in mid-run done");
  endtask

  initial begin
    forever begin
      @(negedge ref_clk);
      #1;
      if (exp_q.size() > 0) check_lamp(exp_q.pop_front(), glow);
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (seq[i]) run(seq[i]);
    reset_mid();
    repeat (2) @(negedge ref_clk);
    #2;
    report_and_stop();
  end

  initial begin
    repeat (2000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
endmodule
